//--- logic/irido_pkg.sv
// Package: constants for the interrupt-return and idle instruction block
package irido_pkg;
    localparam int PC_W = 13;
    localparam int STK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam logic [13:0] OP_RETURN_FROM_INTERRUPT = 14'h0009;
    localparam logic [13:0] OP_NOP_MASK = 14'h3f9f;
    localparam logic [13:0] OP_NOP = 14'h0000;
    localparam logic [13:0] OP_OPTION_LOAD = 14'h0062;
    localparam int GLB_INT_EN_BIT = 7;
    localparam logic [1:0] Q_PER_CYCLE_M1 = 2'h3;
    localparam logic [1:0] Q_RESET = 2'h0;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [7:0] INT_CTRL_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;
    typedef enum logic [1:0] {
        IRIDO_EXEC = 2'b00,
        IRIDO_SECOND = 2'b01
    } irido_state_t;
endpackage

//--- logic/irido_qclk.sv
// Quadrature phase generator: four oscillator periods per instruction cycle
module irido_qclk
    import irido_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Phase outputs
    output logic [1:0] q_phase,
    output logic q4_last
);
    logic [1:0] q_r;

    // Free-running two-bit phase counter
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q_r <= Q_RESET;
        end else begin
            q_r <= q_r + 2'h1;
        end
    end

    assign q_phase = q_r;
    assign q4_last = (q_r == Q_PER_CYCLE_M1);
endmodule // irido_qclk

//--- logic/irido_core.sv
// Execution of return-from-interrupt, no-operation and option-load ops
module irido_core
    import irido_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Instruction fetched for the next cycle
    input wire logic [13:0] instr,
    // Call stack push from the rest of the core
    input wire logic push_req,
    input wire logic [PC_W-1:0] push_data,
    // Interrupt control write from the rest of the core
    input wire logic int_ctrl_we,
    input wire logic [7:0] int_ctrl_wdata,
    // Working register value for option load
    input wire logic [7:0] w_reg,
    // Status flags in from the core
    input wire logic [7:0] status_in,
    // Outputs
    output logic [PC_W-1:0] pc_r,
    output logic [7:0] interrupt_control_register_r,
    output logic [7:0] option_r,
    output logic [7:0] status_r,
    output logic cycle_end_r,
    output logic busy_r
);
    logic [1:0] q_phase;
    logic q4_last;
    logic [PC_W-1:0] stack_r [STK_DEPTH];
    logic [SP_W-1:0] sp_r;
    logic [PC_W-1:0] top_of_stack;
    irido_state_t state_r;
    logic is_rfi;
    logic is_nop;
    logic is_opt;
    logic exec_rfi;

    irido_qclk u_qclk (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .q_phase(q_phase),
        .q4_last(q4_last)
    );

    // Decode; a masked compare covers the don't-care bits of no-op
    assign is_rfi = (instr == OP_RETURN_FROM_INTERRUPT);
    assign is_nop = ((instr & OP_NOP_MASK) == OP_NOP);
    assign is_opt = (instr == OP_OPTION_LOAD);
    assign top_of_stack = stack_r[sp_r - 3'h1];
    assign exec_rfi = q4_last && state_r == IRIDO_EXEC && is_rfi;

    // Two-cycle sequencer: the second cycle is a flushed fetch
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= IRIDO_EXEC;
        end else if (q4_last) begin
            case (state_r)
                IRIDO_EXEC: begin
                    if (is_rfi) begin
                        state_r <= IRIDO_SECOND;
                    end
                end
                default: begin
                    state_r <= IRIDO_EXEC;
                end
            endcase
        end
    end

    // Circular stack; overflow wraps silently like the real hardware
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sp_r <= SP_RESET;
        end else if (exec_rfi) begin
            sp_r <= sp_r - 3'h1;
        end else if (push_req) begin
            sp_r <= sp_r + 3'h1;
        end
    end

    // Stack storage, no reset needed for data
    always_ff @(posedge clk_sys) begin
        if (push_req && !exec_rfi) begin
            stack_r[sp_r] <= push_data;
        end
    end

    // Program counter: advances once per executed cycle, loads the stack top on return, holds in the flushed cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pc_r <= PC_RESET;
        end else if (exec_rfi) begin
            pc_r <= top_of_stack;
        end else if (q4_last && state_r == IRIDO_EXEC) begin
            pc_r <= pc_r + 13'h0001;
        end
    end

    // Interrupt control; the return sets the global enable bit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            interrupt_control_register_r <= INT_CTRL_RESET;
        end else begin
            if (int_ctrl_we) begin
                interrupt_control_register_r <= int_ctrl_wdata;
            end
            // Later assignment wins: the return beats a same-edge write
            if (exec_rfi) begin
                interrupt_control_register_r[GLB_INT_EN_BIT] <= 1'b1;
            end
        end
    end

    // Option load kept for old code only; direct writes are preferred
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            option_r <= OPTION_RESET;
        end else if (q4_last && state_r == IRIDO_EXEC && is_opt) begin
            option_r <= w_reg;
        end
    end

    // Status follows the core except during return or no-op
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_r <= STATUS_RESET;
        end else if (!(is_rfi || is_nop || state_r == IRIDO_SECOND)) begin
            status_r <= status_in;
        end
    end

    // Cycle boundary and busy indications
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cycle_end_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            cycle_end_r <= q4_last;
            // Drops at the flushed cycle's last edge, so it stands 4 clocks
            busy_r <= (state_r == IRIDO_SECOND && !q4_last) || exec_rfi;
        end
    end

    property p_cycle4;
        @(posedge clk_sys) disable iff (sys_rst)
        cycle_end_r |=> !cycle_end_r [*3] ##1 cycle_end_r;
    endproperty
    a_cycle4: assert property (p_cycle4) else $error("cycle not 4");

    property p_gie;
        @(posedge clk_sys) disable iff (sys_rst)
        exec_rfi |=> interrupt_control_register_r[GLB_INT_EN_BIT];
    endproperty
    a_gie: assert property (p_gie) else $error("enable not set");

    property p_pc_pop;
        @(posedge clk_sys) disable iff (sys_rst)
        exec_rfi |=> pc_r == $past(top_of_stack);
    endproperty
    a_pc_pop: assert property (p_pc_pop) else $error("pc not popped");

    sequence s_rfi_second;
        state_r == IRIDO_SECOND [*4];
    endsequence
    property p_two_cycles;
        @(posedge clk_sys) disable iff (sys_rst)
        exec_rfi |=> s_rfi_second ##1 state_r == IRIDO_EXEC;
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("not two");

    property p_nop_pc;
        @(posedge clk_sys) disable iff (sys_rst)
        (q4_last && state_r == IRIDO_EXEC && is_nop)
            |=> pc_r == $past(pc_r) + 13'h0001;
    endproperty
    a_nop_pc: assert property (p_nop_pc) else $error("nop pc");

    property p_nop_status;
        @(posedge clk_sys) disable iff (sys_rst)
        is_nop |=> $stable(status_r);
    endproperty
    a_nop_status: assert property (p_nop_status) else $error("nop flag");

    // Cycle end pulse lands just after the phase counter wraps
    property p_phase;
        @(posedge clk_sys) disable iff (sys_rst)
        cycle_end_r |-> q_phase == Q_RESET;
    endproperty
    a_phase: assert property (p_phase) else $error("phase off");

    sequence s_busy_four;
        busy_r [*4];
    endsequence
    property p_busy;
        @(posedge clk_sys) disable iff (sys_rst)
        exec_rfi |=> s_busy_four ##1 !busy_r;
    endproperty
    a_busy: assert property (p_busy) else $error("busy length");

    property p_ret_sp;
        @(posedge clk_sys) disable iff (sys_rst)
        exec_rfi |=> sp_r == $past(sp_r) - 3'h1;
    endproperty
    a_ret_sp: assert property (p_ret_sp) else $error("no pop");

    property p_second_pc;
        @(posedge clk_sys) disable iff (sys_rst)
        state_r == IRIDO_SECOND |=> $stable(pc_r);
    endproperty
    a_second_pc: assert property (p_second_pc) else $error("pc moved");

    property p_second_status;
        @(posedge clk_sys) disable iff (sys_rst)
        state_r == IRIDO_SECOND |=> $stable(status_r);
    endproperty
    a_second_status: assert property (p_second_status) else $error("flag");

    property p_second_option;
        @(posedge clk_sys) disable iff (sys_rst)
        state_r == IRIDO_SECOND |=> $stable(option_r);
    endproperty
    a_second_option: assert property (p_second_option) else $error("opt");

    property p_nop_option;
        @(posedge clk_sys) disable iff (sys_rst)
        (q4_last && state_r == IRIDO_EXEC && is_nop) |=> $stable(option_r);
    endproperty
    a_nop_option: assert property (p_nop_option) else $error("nop opt");
endmodule // irido_core

//--- tb/test_interrupt_return_and_idle_ops.sv
// Self-checking bench for the return, idle and option-load instructions
module test_interrupt_return_and_idle_ops import irido_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'h0, sys_rst = 1'h1, push_req = 1'h0, int_ctrl_we = 1'h0;
    logic [13:0] instr = 14'h0000;
    logic [PC_W-1:0] push_data = 13'h0000, pc_r, exp_pc = 13'h0000;
    logic [7:0] int_ctrl_wdata = 8'h00, w_reg = 8'h00, status_in = 8'h00;
    logic [7:0] interrupt_control_register_r, option_r, status_r;
    logic [7:0] s_exp, ic_exp, opt_exp;
    logic cycle_end_r, busy_r;
    logic [PC_W-1:0] stk[$];
    // Lag counts clocks spent by push or write since the last cycle end
    int fail_count = 0, samples_checked = 0, seed = 38, waited, lag = 0;
    // Free-running 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;
    irido_core u_irido_core (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .instr(instr), .push_req(push_req), .push_data(push_data),
        .int_ctrl_we(int_ctrl_we), .int_ctrl_wdata(int_ctrl_wdata),
        .w_reg(w_reg), .status_in(status_in), .pc_r(pc_r),
        .interrupt_control_register_r(interrupt_control_register_r),
        .option_r(option_r), .status_r(status_r),
        .cycle_end_r(cycle_end_r), .busy_r(busy_r));
    // Compare one value, four-state exact
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    // Expected interrupt control after a return: global enable forced on
    function automatic logic [7:0] ic_after_ret(input logic [7:0] v);
        ic_after_ret = v;
        ic_after_ret[GLB_INT_EN_BIT] = 1'h1;
    endfunction
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Present one instruction, wait for its cycle end, bounded
    task op(input logic [13:0] code);
        instr = code;
        waited = 0;
        do begin
            @(negedge clk_sys);
            waited++;
        end while (cycle_end_r !== 1'h1 && waited < 12);
        if (waited >= 12) begin
            fail_count++;
            end_sim;
        end
        chk(waited + lag, 4);
        lag = 0;
    endtask
    // Single-clock push, mirrored in the bench stack
    task push(input logic [PC_W-1:0] v);
        push_req = 1'h1;
        push_data = v;
        @(negedge clk_sys);
        push_req = 1'h0;
        stk.push_back(v);
        lag++;
    endtask
    // Interrupt control write with the global enable kept clear
    task wr_ic;
        int_ctrl_we = 1'h1;
        int_ctrl_wdata = 8'($random(seed)) & 8'h7f;
        ic_exp = int_ctrl_wdata;
        @(negedge clk_sys);
        int_ctrl_we = 1'h0;
        lag++;
    endtask
    // Idle instruction with random don't-care bits and noisy status input
    task nop_chk;
        status_in = 8'($random(seed));
        op((14'($random(seed)) & ~OP_NOP_MASK) | OP_NOP);
        exp_pc++;
        chk(pc_r, exp_pc);
        chk(status_r, s_exp);
        chk(interrupt_control_register_r, ic_exp);
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'h0;
        chk(pc_r, 0);
        chk(interrupt_control_register_r, 0);
        chk(option_r, 8'hff);
        chk(status_r, 0);
        chk(busy_r, 0);
        $display("reset test done");
        // Option load gives a known status and option value
        w_reg = 8'($random(seed));
        status_in = 8'($random(seed));
        s_exp = status_in;
        opt_exp = w_reg;
        ic_exp = 8'h00;
        op(OP_OPTION_LOAD);
        exp_pc++;
        chk(option_r, opt_exp);
        chk(status_r, s_exp);
        chk(pc_r, exp_pc);
        $display("option load test done");
        // Push five stack entries between idle instructions
        repeat (5) begin
            nop_chk();
            push(13'($random(seed)));
        end
        wr_ic();
        nop_chk();
        $display("stack fill test done");
        // Unwind with returns; the second cycle must flush an option load
        while (stk.size() > 0) begin
            status_in = 8'($random(seed));
            op(OP_RETURN_FROM_INTERRUPT);
            exp_pc = stk.pop_back();
            ic_exp = ic_after_ret(ic_exp);
            chk(pc_r, exp_pc);
            chk(interrupt_control_register_r, ic_exp);
            chk(status_r, s_exp);
            chk(busy_r, 1);
            w_reg = ~opt_exp;
            status_in = 8'($random(seed));
            op(OP_OPTION_LOAD);
            chk(pc_r, exp_pc);
            chk(option_r, opt_exp);
            chk(status_r, s_exp);
            chk(busy_r, 0);
            // Back in normal flow the held option op lets status follow
            s_exp = status_in;
            wr_ic();
            nop_chk();
        end
        $display("return unwind test done");
        end_sim();
    end
endmodule // test_interrupt_return_and_idle_ops
